// ==== common/eaf_pkg.sv ====
// Package for the external address filter port: constants, states, carriers
package eaf_pkg;
	localparam int unsigned ADDR_W = 48;                 // Destination address width
	localparam int unsigned BYTE_W = 8;                  // Octet width on the receive path
	localparam int unsigned ADDR_BYTES = 6;              // Octets in a destination address
	localparam real CLK_PERIOD_NS = 25.0;                // Core clock period
	localparam int unsigned MIN_EN_PERIODS = 4;          // Least enable length, receive clocks
	localparam logic [3:0] MIN_EN_CYC = 4'(MIN_EN_PERIODS); // Enable hold, in core cycles
	localparam logic [2:0] BYTE_CNT_LAST = 3'(ADDR_BYTES - 1); // Index of last address octet
	localparam logic [2:0] BYTE_CNT_RST = 3'h0;          // Octet counter reset
	localparam logic [3:0] HOLD_RST = 4'h0;              // Hold counter reset
	localparam logic [3:0] HOLD_ONE = 4'h1;              // Hold counter step

	// Sequencer states, one-hot
	typedef enum logic [3:0]
	{
		EAF_IDLE = 4'h1,   // Waiting for a frame start
		EAF_GATHER = 4'h2, // Collecting address octets
		EAF_ASK = 4'h4,    // Enable high, waiting for verdict
		EAF_WAIT = 4'h8    // Verdict given, waiting for frame end
	} eaf_state_e;

	// Receive octet stream from the MAC receive path
	typedef struct packed
	{
		logic sof;              // First octet of destination address
		logic valid;            // Octet strobe
		logic eof;              // Frame over
		logic [7:0] data;       // Octet, first on the wire first
	} eaf_rx_s;

	// Verdict towards the receive path
	typedef struct packed
	{
		logic done;             // One-cycle pulse: decision made
		logic keep;             // Keep frame when done
	} eaf_verdict_s;

	// State of the port, all but the en_len check helper
	typedef struct packed
	{
		eaf_state_e state;      // Sequencer state
		logic [47:0] addr;      // Address shift register, bus source
		logic [2:0] byte_cnt;   // Octets gathered
		logic [3:0] hold;       // Enable cycles elapsed
		logic enable;           // Enable output register
		logic hit_valid_s1;     // First synchroniser stage
		logic hit_valid_s2;     // Second synchroniser stage
		logic hit_s1;           // First synchroniser stage
		logic hit_s2;           // Second synchroniser stage
		logic got;              // Verdict captured
		logic got_keep;         // Captured verdict
		eaf_verdict_s verdict;  // Verdict output register
	} eaf_state_s;
endpackage : eaf_pkg

// ==== rtl/eaf_port.sv ====
// External destination address filter port of the MAC receive path
`timescale 1ns/1ps
`default_nettype none
module eaf_port
(
	input wire logic core_clk,                          // Receive clock, 40 MHz
	input wire logic resetn,                            // Asynchronous reset, active low
	input wire eaf_pkg::eaf_rx_s rx,                    // Octet stream from receive path
	input wire logic addr_hit,                          // Checker verdict pin
	input wire logic addr_hit_valid,                    // Checker verdict valid pin
	output logic addr_check_enable,                     // Address valid, starts checker
	output logic [47:0] dest_addr_out,                  // Destination address bus
	output eaf_pkg::eaf_verdict_s verdict               // Keep or drop decision
);
	eaf_pkg::eaf_state_s cur; // Registered state
	eaf_pkg::eaf_state_s nxt; // Next state

	// Verdict pins come from outside logic, so two flops; only stage two is read
	logic hit_ok; // Synchronised verdict valid qualified by enable
	assign hit_ok = cur.hit_valid_s2 && cur.enable;
	logic frame_over; // Frame end seen now or earlier in the ask window
	assign frame_over = rx.eof || (cur.byte_cnt == eaf_pkg::BYTE_CNT_RST);

	// Next-state logic
	// One frame at a time: gather six octets, raise enable, hold it for the
	// least time, take the first qualified verdict, then wait for the frame end.
	// A frame end seen while asking is remembered so the block never sticks.
	always_comb
	begin
		nxt = cur;
		nxt.hit_valid_s1 = addr_hit_valid;
		nxt.hit_valid_s2 = cur.hit_valid_s1;
		nxt.hit_s1 = addr_hit;
		nxt.hit_s2 = cur.hit_s1;
		nxt.verdict.done = 1'b0;
		case (cur.state)
			eaf_pkg::EAF_IDLE:
			begin
				// New frame: first octet may arrive with the start mark
				if (rx.sof && rx.valid)
				begin
					nxt.addr = {cur.addr[39:0], rx.data};
					nxt.byte_cnt = eaf_pkg::BYTE_CNT_RST + 3'h1;
					nxt.state = eaf_pkg::EAF_GATHER;
				end
			end
			eaf_pkg::EAF_GATHER:
			begin
				if (rx.eof)
				begin
					// Runt frame: address incomplete, never ask
					nxt.state = eaf_pkg::EAF_IDLE;
				end
				else if (rx.valid)
				begin
					nxt.addr = {cur.addr[39:0], rx.data};
					if (cur.byte_cnt == eaf_pkg::BYTE_CNT_LAST)
					begin
						// Address complete: raise enable with bus already stable
						nxt.enable = 1'b1;
						nxt.hold = eaf_pkg::HOLD_RST;
						nxt.got = 1'b0;
						nxt.state = eaf_pkg::EAF_ASK;
					end
					else
					begin
						nxt.byte_cnt = cur.byte_cnt + 3'h1;
					end
				end
			end
			eaf_pkg::EAF_ASK:
			begin
				// Address frozen here; the hold counter counts and the octet counter only clears on frame end
				if (cur.hold != eaf_pkg::MIN_EN_CYC)
				begin
					nxt.hold = cur.hold + eaf_pkg::HOLD_ONE;
				end
				if (hit_ok && !cur.got)
				begin
					nxt.got = 1'b1;
					nxt.got_keep = cur.hit_s2;
				end
				// Octet counter is idle here, so it doubles as the frame-over mark;
				// an end that comes early must not be lost while the hold runs
				if (rx.eof)
				begin
					nxt.byte_cnt = eaf_pkg::BYTE_CNT_RST;
				end
				// Drop enable after the least hold once a verdict is captured
				if (cur.got && (cur.hold >= eaf_pkg::MIN_EN_CYC - eaf_pkg::HOLD_ONE))
				begin
					nxt.enable = 1'b0;
					nxt.verdict.done = 1'b1;
					nxt.verdict.keep = cur.got_keep;
					if (frame_over)
					begin
						// Frame already over: nothing left to sit out
						nxt.state = eaf_pkg::EAF_IDLE;
					end
					else
					begin
						nxt.state = eaf_pkg::EAF_WAIT;
					end
				end
				else if (frame_over && !hit_ok)
				begin
					// Frame ended with no answer: drop it after the least hold;
					// an answer sampled in this very cycle still gets its turn
					nxt.enable = (cur.hold >= eaf_pkg::MIN_EN_CYC - eaf_pkg::HOLD_ONE) ? 1'b0 : 1'b1;
					if (!nxt.enable)
					begin
						nxt.verdict.done = 1'b1;
						nxt.verdict.keep = 1'b0;
						nxt.state = eaf_pkg::EAF_IDLE;
					end
				end
			end
			eaf_pkg::EAF_WAIT:
			begin
				// Sit out the rest of the frame
				if (rx.eof)
				begin
					nxt.state = eaf_pkg::EAF_IDLE;
				end
			end
			default:
			begin
				nxt.state = eaf_pkg::EAF_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cur <= '{state: eaf_pkg::EAF_IDLE, addr: 48'h0, byte_cnt: eaf_pkg::BYTE_CNT_RST,
				hold: eaf_pkg::HOLD_RST, enable: 1'b0, hit_valid_s1: 1'b0,
				hit_valid_s2: 1'b0, hit_s1: 1'b0, hit_s2: 1'b0, got: 1'b0,
				got_keep: 1'b0, verdict: '{done: 1'b0, keep: 1'b0}};
		end
		else
		begin
			cur <= nxt;
		end
	end

	assign addr_check_enable = cur.enable;
	assign dest_addr_out = cur.addr;
	assign verdict = cur.verdict;

	// Helper: cycles enable has been high
	logic [3:0] en_len; // Saturating enable run length
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			en_len <= 4'h0;
		end
		else if (!cur.enable)
		begin
			en_len <= 4'h0;
		end
		else if (en_len != 4'hF)
		begin
			en_len <= en_len + 4'h1;
		end
	end

	// Checks on the port's own outputs and state, all on the core clock
	en_min_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$fell(addr_check_enable) |-> en_len >= eaf_pkg::MIN_EN_CYC)
		else $error("enable dropped before four cycles");

	addr_stable_a: assert property (@(posedge core_clk) disable iff (!resetn)
		addr_check_enable && $past(addr_check_enable) |-> $stable(dest_addr_out))
		else $error("address moved while enabled");

	addr_ready_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(addr_check_enable) |-> cur.state == eaf_pkg::EAF_ASK && cur.hold == 4'h0)
		else $error("enable raised outside ask state");

	ask_only_en_a: assert property (@(posedge core_clk) disable iff (!resetn)
		addr_check_enable |-> cur.state == eaf_pkg::EAF_ASK)
		else $error("enable high outside ask state");

	keep_verdict_a: assert property (@(posedge core_clk) disable iff (!resetn)
		verdict.done && verdict.keep |-> $past(cur.got_keep))
		else $error("kept frame without a hit");

	late_hit_kept_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cur.state == eaf_pkg::EAF_ASK && cur.got && cur.got_keep
		&& cur.hold >= eaf_pkg::MIN_EN_CYC - eaf_pkg::HOLD_ONE
		|=> verdict.done && verdict.keep)
		else $error("hit not kept");

	drop_verdict_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cur.state == eaf_pkg::EAF_ASK && cur.got && !cur.got_keep && cur.hold >= 4'h3
		|=> verdict.done && !verdict.keep)
		else $error("miss not dropped");

	no_answer_drop_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cur.state == eaf_pkg::EAF_ASK && !cur.got && !hit_ok
		&& cur.byte_cnt == eaf_pkg::BYTE_CNT_RST
		&& cur.hold >= eaf_pkg::MIN_EN_CYC - eaf_pkg::HOLD_ONE
		|=> verdict.done && !verdict.keep && !addr_check_enable)
		else $error("ended frame without answer not dropped");

	valid_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(cur.got) |-> $past(cur.hit_valid_s2) && $past(cur.enable))
		else $error("verdict taken without valid");

	sync_path_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(cur.got) |-> cur.got_keep == $past(cur.hit_s2))
		else $error("verdict not taken from synchronised pin");

	full_addr_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(addr_check_enable) |-> dest_addr_out[7:0] == $past(rx.data))
		else $error("last octet missing from bus");

	done_clears_en_a: assert property (@(posedge core_clk) disable iff (!resetn)
		verdict.done |-> !addr_check_enable)
		else $error("enable high after verdict");

	done_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
		verdict.done |=> !verdict.done)
		else $error("decision pulse longer than one cycle");
endmodule : eaf_port
`default_nettype wire

// ==== bench/eaf_checker_model.sv ====
// Behavioural model of the external address checker
`timescale 1ns/1ps
`default_nettype none
module eaf_checker_model
#(
	parameter logic [47:0] KNOWN_ADDR = 48'h0A1B2C3D4E5F // Address it recognises
)
(
	input wire logic core_clk, // Receive clock
	input wire logic resetn, // Reset, active low
	input wire logic addr_check_enable, // Starts evaluation
	input wire logic [47:0] dest_addr_out, // Address to judge
	input wire logic [3:0] lat, // Cycles before answering
	output logic addr_hit_valid, // Verdict valid
	output logic addr_hit // Verdict
);
	logic [3:0] cnt; // Cycles since enable rose
	// Verdict pin churns while invalid, so a stale value never helps
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 4'h0;
			addr_hit_valid <= 1'b0;
			addr_hit <= 1'b0;
		end
		else if (addr_check_enable)
		begin
			cnt <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
			addr_hit_valid <= (cnt >= lat);
			addr_hit <= (cnt >= lat) ? (dest_addr_out == KNOWN_ADDR) : ~addr_hit;
		end
		else
		begin
			cnt <= 4'h0;
			addr_hit_valid <= 1'b0;
			addr_hit <= ~addr_hit;
		end
	end
endmodule : eaf_checker_model
`default_nettype wire

// ==== bench/eaf_port_bench.sv ====
// Self-checking bench for the external address filter port
`timescale 1ns/1ps
`default_nettype none
module eaf_port_bench;
	localparam logic [47:0] KNOWN = 48'h0A1B2C3D4E5F; // Address the checker keeps
	logic core_clk = 1'b0; // Receive clock
	logic resetn = 1'b0; // Reset, active low
	eaf_pkg::eaf_rx_s rx = '0; // Octet stream
	logic hit; // Checker verdict
	logic hit_valid; // Checker verdict valid
	logic enable; // Check enable
	logic [47:0] addr; // Address bus
	eaf_pkg::eaf_verdict_s verdict; // Keep or drop
	logic [3:0] lat = 4'h0; // Checker latency
	int error_cnt = 0; // Mismatches
	int total_checks = 0; // Comparisons
	always #12.5 core_clk = ~core_clk;
	eaf_port eaf_port_inst (.core_clk(core_clk), .resetn(resetn), .rx(rx), .addr_hit(hit),
		.addr_hit_valid(hit_valid), .addr_check_enable(enable), .dest_addr_out(addr),
		.verdict(verdict));
	eaf_checker_model #(.KNOWN_ADDR(KNOWN)) eaf_checker_model_inst (.core_clk(core_clk),
		.resetn(resetn), .addr_check_enable(enable), .dest_addr_out(addr), .lat(lat),
		.addr_hit_valid(hit_valid), .addr_hit(hit));
	// Compare one flag
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// Compare the address bus
	task automatic chk_addr(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t address %h expected %h", $time, got, exp);
		end
	endtask : chk_addr
	// Print counts and end the run
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// Send n address octets, first on the wire first, then one end slot; caller clears
	task automatic send(input logic [47:0] a, input int n, input logic fin);
		for (int i = 0; i < n; i++)
		begin
			@(posedge core_clk);
			rx <= '{sof: (i == 0), valid: 1'b1, eof: 1'b0, data: a[47 - 8 * i -: 8]};
		end
		@(posedge core_clk);
		rx <= '{sof: 1'b0, valid: 1'b0, eof: fin, data: 8'h00};
	endtask : send
	// Whole frame: bus held while enabled, verdict judged while done stands
	task automatic frame(input logic [47:0] a, input logic [3:0] l, input logic k,
		input logic f);
		int n;
		int w;
		logic seen;
		n = 0;
		w = 0;
		seen = 1'b0;
		lat <= l;
		send(a, 6, f);
		// Enable rises at the edge send returns on, so every enabled cycle is seen
		while (!seen && w < 40)
		begin
			@(negedge core_clk);
			w++;
			seen = (verdict.done === 1'b1);
			if (seen)
			begin
				chk_bit(verdict.keep, k);
			end
			if (enable === 1'b1)
			begin
				n++;
				chk_addr(addr, a);
			end
			@(posedge core_clk);
			rx <= '0;
		end
		if (!seen)
		begin
			error_cnt++;
			$display("ERROR %0t no decision", $time);
			give_verdict();
		end
		chk_bit(n >= eaf_pkg::MIN_EN_PERIODS, 1'b1);
		send(a, 0, 1'b1);
		@(posedge core_clk);
		rx <= '0;
		$display("frame %h latency %0d done", a, l);
	endtask : frame
	// Frame cut short before the sixth octet never enables the checker
	task automatic abandon();
		send(KNOWN, 3, 1'b1);
		@(posedge core_clk);
		rx <= '0;
		repeat (12)
		begin
			@(negedge core_clk);
			chk_bit(enable | verdict.done, 1'b0);
		end
		$display("short frame done");
	endtask : abandon
	// Reset while the checker is enabled clears enable, the done pulse and the address bus
	task automatic reset_mid();
		lat <= 4'hC;
		send(KNOWN, 6, 1'b0);
		@(negedge core_clk);
		chk_bit(enable, 1'b1);
		@(posedge core_clk);
		rx <= '0;
		resetn <= 1'b0;
		@(negedge core_clk);
		chk_bit(enable | verdict.done, 1'b0);
		chk_addr(addr, 48'h000000000000);
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		$display("reset during check done");
	endtask : reset_mid
	initial
	begin
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		frame(KNOWN, 4'h0, 1'b1, 1'b0);
		frame(KNOWN ^ 48'h000000000001, 4'h9, 1'b0, 1'b0);
		frame(KNOWN, 4'hC, 1'b1, 1'b0);
		frame(KNOWN, 4'h0, 1'b1, 1'b1);
		frame(KNOWN, 4'hC, 1'b0, 1'b1);
		abandon();
		reset_mid();
		frame(KNOWN, 4'h0, 1'b1, 1'b0);
		give_verdict();
	end
endmodule : eaf_port_bench
`default_nettype wire
